// *** verilog/wdt_consts.vh ***
// Constants for the watchdog timer block: register map, fields, resets and timing.
`ifndef WDT_CONSTS_VH
`define WDT_CONSTS_VH

// Register indices; the byte address is four times the index.
`define IDX_UNIT      10'h0F1
`define IDX_VALUE     10'h0F2
`define IDX_CONFIG    10'h0F3
`define IDX_CONTROL   10'h0F4
`define IDX_INTSTAT   10'h0F5
`define IDX_INTMASK   10'h0F6
`define ADDR_W        12

// Reset values.
`define RST_UNIT      8'h00
`define RST_VALUE     8'h00
`define RST_CONFIG    8'h00
`define RST_CONTROL   8'h00
`define RST_INT       2'h0

// Field positions.
`define UNIT_SEC_BIT   7
`define CFG_GAME_BIT   0
`define CFG_KBD_BIT    1
`define CFG_MOUSE_BIT  2
`define CFG_MAP_HI     7
`define CFG_MAP_LO     4
`define CTL_STAT_BIT   0
`define CTL_FORCE_BIT  2
`define CTL_KBCEN_BIT  3
`define EVT_TIMEOUT    0
`define EVT_FORCED     1

// Interrupt mapping codes.
`define MAP_DISABLE    4'h0
`define MAP_INVALID    4'h2

// Timing.
`define SECOND_NS      1000000000
`define CLK_PERIOD_NS  4
`define SEC_PER_MIN    6'd60
`define VALUE_ZERO     8'h00
`define VALUE_ONE      8'h01

// Bus answers.
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2

`endif

// *** verilog/watchdog_timer_with_irq_map.v ***
// Watchdog timer with restart sources, forced time-out and ISA IRQ mapping, on AXI4-Lite.
// Notes on behaviour
// - Unit bit selects minutes or seconds; minutes default.
// - Zero time-out value never times out.
// - Nonzero value counts 1 to 255 units.
// - Game port access restarts when enabled.
// - Keyboard interrupt restarts when enabled.
// - Mouse interrupt restarts when enabled.
// - Config high nibble maps time-out IRQ line.
// - Status bit shows time-out occurred, read/write.
// - Force bit causes time-out, self-clearing.
// - Enabled reset-request rising edge forces time-out.
// - Edge detector ORed with software force.
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ps
`include "wdt_consts.vh"

module watchdog_timer_with_irq_map #(
  parameter integer CYCLES_PER_SEC = `SECOND_NS / `CLK_PERIOD_NS,
  parameter integer PRESC_W        = 28
) (
  input  wire                core_clk,
  input  wire                rst_b,
  input  wire [`ADDR_W-1:0]  s_axi_awaddr,
  input  wire                s_axi_awvalid,
  output wire                s_axi_awready,
  input  wire [31:0]         s_axi_wdata,
  input  wire [3:0]          s_axi_wstrb,
  input  wire                s_axi_wvalid,
  output wire                s_axi_wready,
  output reg  [1:0]          s_axi_bresp,
  output reg                 s_axi_bvalid,
  input  wire                s_axi_bready,
  input  wire [`ADDR_W-1:0]  s_axi_araddr,
  input  wire                s_axi_arvalid,
  output wire                s_axi_arready,
  output reg  [31:0]         s_axi_rdata,
  output reg  [1:0]          s_axi_rresp,
  output reg                 s_axi_rvalid,
  input  wire                s_axi_rready,
  input  wire                gamePortAccess,
  input  wire                kbdIrq,
  input  wire                mouseIrq,
  input  wire                kbcResetRequestOut,
  output reg  [15:0]         isaIrq,
  output wire                irqOut
);

  localparam integer       PRESC_LAST = CYCLES_PER_SEC - 1;
  localparam [PRESC_W-1:0] PRESC_MAX  = PRESC_LAST[PRESC_W-1:0];

  // Register state.
  reg  [7:0]           unitQ;
  reg  [7:0]           valueQ;
  reg  [7:0]           configQ;
  reg                  statusQ;
  reg                  kbcEnQ;
  reg  [1:0]           intStatQ;
  reg  [1:0]           intMaskQ;

  // Bus channel holding registers.
  reg                  awHeldQ;
  reg  [`ADDR_W-1:0]   awAddrQ;
  reg                  wHeldQ;
  reg  [31:0]          wDataQ;
  reg  [3:0]           wStrbQ;

  // Timing state.
  reg  [PRESC_W-1:0]   prescQ;
  reg  [5:0]           minCntQ;
  reg  [7:0]           elapsedQ;
  reg                  kbcPrevQ;
  reg                  kbdPrevQ;
  reg                  mousePrevQ;

  wire [9:0]           wIdx;
  wire [9:0]           rIdx;
  wire                 doWrite;
  wire                 lane0;
  wire                 wrUnit;
  wire                 wrValue;
  wire                 wrConfig;
  wire                 wrControl;
  wire                 wrIntStat;
  wire                 wrIntMask;
  wire                 wrMapped;
  wire                 secTick;
  wire                 minTick;
  wire                 unitTick;
  wire                 armed;
  wire                 restartSrc;
  wire                 statusCleared;
  wire                 restart;
  wire                 timeoutEvt;
  wire                 swForce;
  wire                 kbcEdge;
  wire                 forceEvt;
  wire                 setStatus;
  wire [3:0]           mapCode;
  wire [1:0]           intEvents;
  wire                 statusD;

  // The channels are accepted independently; a held one blocks until the response is taken.
  assign s_axi_awready = ~awHeldQ & ~s_axi_bvalid;
  assign s_axi_wready  = ~wHeldQ & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign doWrite       = awHeldQ & wHeldQ & ~s_axi_bvalid;
  assign wIdx          = awAddrQ[`ADDR_W-1:2];
  assign rIdx          = s_axi_araddr[`ADDR_W-1:2];
  assign lane0         = doWrite & wStrbQ[0];

  // Write decode; every register fits in the low eight bits, so only byte lane 0 matters.
  assign wrUnit    = lane0 & (wIdx == `IDX_UNIT);
  assign wrValue   = lane0 & (wIdx == `IDX_VALUE);
  assign wrConfig  = lane0 & (wIdx == `IDX_CONFIG);
  assign wrControl = lane0 & (wIdx == `IDX_CONTROL);
  assign wrIntStat = lane0 & (wIdx == `IDX_INTSTAT);
  assign wrIntMask = lane0 & (wIdx == `IDX_INTMASK);
  assign wrMapped  = (wIdx == `IDX_UNIT) | (wIdx == `IDX_VALUE) | (wIdx == `IDX_CONFIG) |
                     (wIdx == `IDX_CONTROL) | (wIdx == `IDX_INTSTAT) | (wIdx == `IDX_INTMASK);

  // Unit ticks: seconds from the prescaler, minutes from sixty seconds.
  assign secTick  = (prescQ == PRESC_MAX);
  assign minTick  = secTick & (minCntQ == `SEC_PER_MIN - 6'd1);
  assign unitTick = unitQ[`UNIT_SEC_BIT] ? secTick : minTick;

  // Restart sources; interrupt inputs count on their rising edge.
  assign restartSrc = (configQ[`CFG_GAME_BIT] & gamePortAccess) |
                      (configQ[`CFG_KBD_BIT] & kbdIrq & ~kbdPrevQ) |
                      (configQ[`CFG_MOUSE_BIT] & mouseIrq & ~mousePrevQ);

  // Forced time-out: software bit acts in the write cycle, the edge only when enabled.
  assign swForce  = wrControl & wDataQ[`CTL_FORCE_BIT];
  assign kbcEdge  = kbcResetRequestOut & ~kbcPrevQ;
  assign forceEvt = swForce | (kbcEnQ & kbcEdge);

  // A zero value or an unacknowledged time-out keeps the counter from firing.
  assign armed      = (valueQ != `VALUE_ZERO) & ~statusQ;
  assign timeoutEvt = armed & unitTick & (elapsedQ == valueQ - `VALUE_ONE) &
                      ~restart;
  assign setStatus  = timeoutEvt | forceEvt;

  // Clearing the status re-arms and restarts the count, unless a force lands at once.
  // A counted time-out needs the status already clear, so only the force can collide here.
  assign statusCleared = wrControl & ~wDataQ[`CTL_STAT_BIT] & statusQ & ~forceEvt;
  assign restart       = restartSrc | wrValue | statusCleared;

  // An event wins over a software write to the status bit.
  assign statusD = setStatus ? 1'b1 :
                   (wrControl ? wDataQ[`CTL_STAT_BIT] : statusQ);

  assign mapCode   = configQ[`CFG_MAP_HI:`CFG_MAP_LO];
  assign intEvents = {forceEvt, timeoutEvt};
  assign irqOut    = |(intStatQ & intMaskQ);

  // Write address and data capture, and the write response.
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      awHeldQ      <= 1'b0;
      awAddrQ      <= {`ADDR_W{1'b0}};
      wHeldQ       <= 1'b0;
      wDataQ       <= 32'h00000000;
      wStrbQ       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeldQ <= 1'b1;
        awAddrQ <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeldQ <= 1'b1;
        wDataQ <= s_axi_wdata;
        wStrbQ <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHeldQ      <= 1'b0;
        wHeldQ       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wrMapped ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read path; the answer comes one edge after the address is taken.
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `RESP_OKAY;
        if (rIdx == `IDX_UNIT) begin
          s_axi_rdata <= {24'h000000, unitQ[`UNIT_SEC_BIT], 7'h00};
        end else if (rIdx == `IDX_VALUE) begin
          s_axi_rdata <= {24'h000000, valueQ};
        end else if (rIdx == `IDX_CONFIG) begin
          s_axi_rdata <= {24'h000000, configQ};
        end else if (rIdx == `IDX_CONTROL) begin
          // The force bit always reads zero because it never holds a value.
          s_axi_rdata <= {28'h0000000, kbcEnQ, 2'h0, statusQ};
        end else if (rIdx == `IDX_INTSTAT) begin
          s_axi_rdata <= {30'h00000000, intStatQ};
        end else if (rIdx == `IDX_INTMASK) begin
          s_axi_rdata <= {30'h00000000, intMaskQ};
        end else begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `RESP_SLVERR;
        end
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Software registers; reserved bits are not stored, so stray ones do no harm.
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      unitQ    <= `RST_UNIT;
      valueQ   <= `RST_VALUE;
      configQ  <= `RST_CONFIG;
      statusQ  <= 1'b0;
      kbcEnQ   <= 1'b0;
      intStatQ <= `RST_INT;
      intMaskQ <= `RST_INT;
    end else begin
      if (wrUnit) begin
        unitQ <= {wDataQ[`UNIT_SEC_BIT], 7'h00};
      end
      if (wrValue) begin
        valueQ <= wDataQ[7:0];
      end
      if (wrConfig) begin
        configQ <= {wDataQ[7:4], 1'b0, wDataQ[2:0]};
      end
      if (wrControl) begin
        kbcEnQ <= wDataQ[`CTL_KBCEN_BIT];
      end
      statusQ <= statusD;
      // Sticky event bits: new events win over a write-one-to-clear.
      intStatQ <= (intStatQ & ~(wrIntStat ? wDataQ[1:0] : 2'h0)) | intEvents;
      if (wrIntMask) begin
        intMaskQ <= wDataQ[1:0];
      end
    end
  end

  // Prescaler and unit counter; a restart realigns both so a full unit follows it.
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      prescQ   <= {PRESC_W{1'b0}};
      minCntQ  <= 6'd0;
      elapsedQ <= 8'h00;
    end else if (restart) begin
      prescQ   <= {PRESC_W{1'b0}};
      minCntQ  <= 6'd0;
      elapsedQ <= 8'h00;
    end else begin
      prescQ <= secTick ? {PRESC_W{1'b0}} : prescQ + {{(PRESC_W-1){1'b0}}, 1'b1};
      if (secTick) begin
        minCntQ <= minTick ? 6'd0 : minCntQ + 6'd1;
      end
      // The elapsed count only runs while armed and clears to zero at the time-out.
      if (!armed || timeoutEvt) begin
        elapsedQ <= 8'h00;
      end else if (unitTick) begin
        elapsedQ <= elapsedQ + 8'h01;
      end
    end
  end

  // Edge detectors; the reset value of one avoids a false edge on a high input at start.
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      kbcPrevQ   <= 1'b1;
      kbdPrevQ   <= 1'b1;
      mousePrevQ <= 1'b1;
    end else begin
      kbcPrevQ   <= kbcResetRequestOut;
      kbdPrevQ   <= kbdIrq;
      mousePrevQ <= mouseIrq;
    end
  end

  // Mapped ISA line follows the status bit; disabled and invalid codes drive nothing.
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      isaIrq <= 16'h0000;
    end else if (statusQ && mapCode != `MAP_DISABLE && mapCode != `MAP_INVALID) begin
      isaIrq <= 16'h0001 << mapCode;
    end else begin
      isaIrq <= 16'h0000;
    end
  end

endmodule // watchdog_timer_with_irq_map

// *** sim/wdt_props.sv ***
// Concurrent checks on the watchdog block's register bus and its isaIrq output.
`timescale 1ns/1ps
module wdt_props (
  input wire        core_clk,
  input wire        rst_b,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire [15:0] isaIrq
);
  // Everything here lives in the single core clock domain.
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  sequence rdTaken; s_axi_arvalid && s_axi_arready; endsequence
  sequence wrTaken; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
  a_read_answer: assert property (rdTaken |=> s_axi_rvalid)
    else $error("read answer missing");
  a_write_answer: assert property (wrTaken |=> ##1 s_axi_bvalid)
    else $error("write response missing");
  a_rvalid_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read data dropped early");
  a_bvalid_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted while busy");
  a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while busy");
  a_irq_one_line: assert property ($onehot0(isaIrq))
    else $error("more than one IRQ line driven");
  a_irq_no_invalid: assert property (!isaIrq[0] && !isaIrq[2])
    else $error("disabled or invalid IRQ code drove a line");
endmodule // wdt_props

bind watchdog_timer_with_irq_map wdt_props wdt_props_i (.*);

// *** sim/kbc_side_model.sv ***
// Keyboard controller and game port stand-in driving the watchdog's event inputs.
`timescale 1ns/1ps
module kbc_side_model (
  input  wire core_clk,
  output reg  gamePortAccess,
  output reg  kbdIrq,
  output reg  mouseIrq,
  output reg  kbcResetRequestOut
);
  // All lines idle low from time zero.
  initial {gamePortAccess, kbdIrq, mouseIrq, kbcResetRequestOut} = 4'h0;
  // One event: a single game access cycle or a short interrupt pulse.
  task pulse(input integer src);
    begin
      @(posedge core_clk);
      gamePortAccess <= (src == 0);
      kbdIrq <= (src == 1);
      mouseIrq <= (src == 2);
      @(posedge core_clk);
      {gamePortAccess, kbdIrq, mouseIrq} <= 3'h0;
    end
  endtask
  // The request stays high at least 1 us (250 cycles) before it may fall.
  task request(input logic lvl);
    begin
      if (!lvl) repeat (250) @(posedge core_clk);
      @(posedge core_clk);
      kbcResetRequestOut <= lvl;
    end
  endtask
endmodule // kbc_side_model

// *** sim/testbench.sv ***
// Self-checking bench for the watchdog timer block.
`timescale 1ns/1ps
`include "wdt_consts.vh"
module testbench;
  localparam integer CPS = 10;
  reg         core_clk = 1'b0, rst_b = 1'b0;
  reg  [11:0] awAddr = 12'h000, arAddr = 12'h000;
  reg  [31:0] wData = 32'h0, d, rs;
  reg         awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
  wire        awReady, wReady, bValid, arReady, rValid, irqOut, game, kbd, mouse, kbcReq;
  wire [1:0]  bResp, rResp;
  wire [31:0] rData;
  wire [15:0] isaIrq;
  integer     num_errors = 0, cmp_count = 0, i, k, en, v, per;
  // Short unit tick keeps the minute case at 600 cycles.
  watchdog_timer_with_irq_map #(.CYCLES_PER_SEC(CPS)) watchdog_timer_with_irq_map_i (
    .core_clk(core_clk), .rst_b(rst_b), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
    .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid),
    .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .gamePortAccess(game), .kbdIrq(kbd), .mouseIrq(mouse), .kbcResetRequestOut(kbcReq),
    .isaIrq(isaIrq), .irqOut(irqOut));
  kbc_side_model kbc_side_model_i (.core_clk(core_clk), .gamePortAccess(game), .kbdIrq(kbd),
    .mouseIrq(mouse), .kbcResetRequestOut(kbcReq));
  // 250 MHz core clock.
  always #2 core_clk = ~core_clk;
  // Address and data go out together; each is dropped once taken.
  task wr(input [9:0] ix, input [7:0] val, output [31:0] r);
    begin
      @(posedge core_clk);
      awAddr <= {ix, 2'h0};
      wData <= {24'h0, val};
      {awValid, wValid, bReady} <= 3'h7;
      do begin
        @(posedge core_clk);
        if (awReady) awValid <= 1'b0;
        if (wReady) wValid <= 1'b0;
      end while (!bValid);
      r = {30'h0, bResp};
      bReady <= 1'b0;
    end
  endtask
  task rd(input [9:0] ix, output [31:0] dt, output [31:0] r);
    begin
      @(posedge core_clk);
      arAddr <= {ix, 2'h0};
      {arValid, rReady} <= 2'h3;
      do begin
        @(posedge core_clk);
        if (arReady) arValid <= 1'b0;
      end while (!rValid);
      dt = rData;
      r = {30'h0, rResp};
      rReady <= 1'b0;
    end
  endtask
  task cmp(input string what, input [31:0] exp, input [31:0] got);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("ERROR %s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  task rchk(input [9:0] ix, input [31:0] exp, input string what);
    begin
      rd(ix, d, rs);
      cmp(what, exp, d);
    end
  endtask
  task t_regs;
    begin
      for (i = 0; i < 6; i = i + 1) rchk(`IDX_UNIT + i[9:0], 32'h0, "reset value");
      wr(`IDX_UNIT, 8'h80, rs);
      rchk(`IDX_UNIT, 32'h80, "unit seconds");
      rd(10'h0F0, d, rs);
      cmp("unmapped rresp", {30'h0, `RESP_SLVERR}, rs);
      wr(10'h0F0, 8'h01, rs);
      cmp("unmapped bresp", {30'h0, `RESP_SLVERR}, rs);
      $display("t_regs done");
    end
  endtask
  // Every map code, each fired by the self-clearing force bit.
  task t_map;
    for (i = 0; i < 16; i = i + 1) begin
      wr(`IDX_CONFIG, {i[3:0], 4'h0}, rs);
      wr(`IDX_CONTROL, 8'h04, rs);
      repeat (2) @(posedge core_clk);
      cmp("mapped irq", (i == 0 || i == 2) ? 32'h0 : 32'h1 << i, {16'h0, isaIrq});
      rchk(`IDX_CONTROL, 32'h01, "forced status");
      wr(`IDX_CONTROL, 8'h00, rs);
    end
  endtask
  // Each source with its enable on must hold off a 20-cycle time-out; off, it must not.
  task t_restart;
    for (k = 0; k < 3; k = k + 1) for (en = 0; en < 2; en = en + 1) begin
      wr(`IDX_CONFIG, en ? 8'h01 << k : 8'h00, rs);
      wr(`IDX_VALUE, 8'h02, rs);
      repeat (3) begin
        repeat (12) @(posedge core_clk);
        kbc_side_model_i.pulse(k);
      end
      rchk(`IDX_CONTROL, {31'h0, en == 0}, "restart status");
      // Stop the count first so that no late time-out leaks into the next test.
      wr(`IDX_VALUE, 8'h00, rs);
      wr(`IDX_CONTROL, 8'h00, rs);
    end
  endtask
  // Count lengths at both ends of the range, zero, and the minute unit.
  task t_count;
    for (i = 0; i < 4; i = i + 1) begin
      v = (i == 1) ? 255 : (i == 2) ? 0 : 1;
      per = ((i == 3) ? 60 * CPS : CPS) * ((v != 0) ? v : 4);
      wr(`IDX_CONFIG, 8'h30, rs);
      wr(`IDX_INTMASK, {7'h0, i != 1}, rs);
      wr(`IDX_UNIT, (i == 3) ? 8'h00 : 8'h80, rs);
      wr(`IDX_VALUE, v[7:0], rs);
      repeat (per - 6) @(posedge core_clk);
      rchk(`IDX_CONTROL, 32'h0, "early status");
      repeat (8) @(posedge core_clk);
      rchk(`IDX_CONTROL, {31'h0, v != 0}, "timeout status");
      cmp("irq line", (v != 0) ? 32'h8 : 32'h0, {16'h0, isaIrq});
      cmp("irq out", {31'h0, v != 0 && i != 1}, {31'h0, irqOut});
      wr(`IDX_INTSTAT, 8'h03, rs);
      cmp("irq cleared", 32'h0, {31'h0, irqOut});
      wr(`IDX_VALUE, 8'h00, rs);
      wr(`IDX_CONTROL, 8'h00, rs);
    end
  endtask
  task t_kbc;
    begin
      wr(`IDX_VALUE, 8'h00, rs);
      kbc_side_model_i.request(1'b1);
      repeat (4) @(posedge core_clk);
      rchk(`IDX_CONTROL, 32'h00, "edge ignored");
      kbc_side_model_i.request(1'b0);
      wr(`IDX_CONTROL, 8'h08, rs);
      kbc_side_model_i.request(1'b1);
      repeat (4) @(posedge core_clk);
      rchk(`IDX_CONTROL, 32'h09, "edge forced");
      wr(`IDX_CONTROL, 8'h08, rs);
      repeat (8) @(posedge core_clk);
      rchk(`IDX_CONTROL, 32'h08, "level held");
      kbc_side_model_i.request(1'b0);
      $display("t_kbc done");
    end
  endtask
  task report_and_stop;
    begin
      $display("checks %0d errors %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  // Main sequence after a 16-cycle reset.
  initial begin
    repeat (16) @(posedge core_clk);
    rst_b <= 1'b1;
    t_regs;
    t_map;
    $display("t_map done");
    t_restart;
    $display("t_restart done");
    t_count;
    $display("t_count done");
    t_kbc;
    report_and_stop;
  end
  // The run needs about 20 us; a hang is cut off well past that.
  initial begin
    #200000;
    num_errors = num_errors + 1;
    report_and_stop;
  end
endmodule // testbench
